// ### shared/pim_pkg.sv
// Constants and types shared by the priority interrupt merger.
package pim_pkg;
    // ************************************************************
    // Source layout and field widths.
    // ************************************************************
    localparam int PIM_NSRC = 8;
    localparam int PIM_NINT = 4;
    localparam int PIM_NEXT = 4;
    localparam int PIM_LVL_W = 3;
    localparam int PIM_SRC_W = 3;
    localparam int PIM_REG_W = 16;
    localparam int PIM_BLOCK_BYTES = 256;

    // ************************************************************
    // Reset values of the settings.
    // ************************************************************
    localparam logic [PIM_LVL_W-1:0] PIM_LVL_LOWEST = 3'h7;
    localparam logic PIM_NEST_RST = 1'h0;
    localparam logic PIM_TRIG_RST = 1'h0;
    localparam logic PIM_MASK_RST = 1'h1;
    localparam logic PIM_CASC_RST = 1'h0;
    localparam logic PIM_SLAVE_RST = 1'h0;
    localparam logic [PIM_LVL_W-1:0] PIM_FLOOR_RST = 3'h7;

    // Delivery handshake states.
    typedef enum logic [1:0] {PIM_IDLE, PIM_OFFER, PIM_SERVE} pim_state_t;
endpackage

// ### logic/pim_pick.sv
// Combinational priority picker for the interrupt merger.
`timescale 1ns/1ps
module pim_pick
#(
    parameter int NSRC = pim_pkg::PIM_NSRC
)
(
    input wire logic [NSRC-1:0] eligible,
    input wire logic [NSRC*pim_pkg::PIM_LVL_W-1:0] levels,
    output logic found,
    output logic [pim_pkg::PIM_SRC_W-1:0] winner,
    output logic [pim_pkg::PIM_LVL_W-1:0] win_level
);
    import pim_pkg::*;

    // Lowest numeric level wins; ties go to the lower source number.
    always_comb
    begin
        found = 1'b0;
        winner = '0;
        win_level = PIM_LVL_LOWEST;
        for (int i = 0; i < NSRC; i++)
        begin
            if (eligible[i] && (!found || levels[i*PIM_LVL_W +: PIM_LVL_W] < win_level))
            begin
                found = 1'b1;
                winner = PIM_SRC_W'(i);
                win_level = levels[i*PIM_LVL_W +: PIM_LVL_W];
            end
        end
    end
endmodule

// ### logic/pim_merger.sv
// Priority interrupt merger: request capture, masking, selection and service tracking.
`timescale 1ns/1ps
module pim_merger
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [pim_pkg::PIM_NINT-1:0] int_req,
    input wire logic [pim_pkg::PIM_NINT-1:0] unit_enable,
    input wire logic [pim_pkg::PIM_NEXT-1:0] ext_req_pin,
    input wire logic cfg_write,
    input wire logic [pim_pkg::PIM_SRC_W-1:0] cfg_src,
    input wire logic [pim_pkg::PIM_REG_W-1:0] cfg_data,
    input wire logic floor_write,
    input wire logic [pim_pkg::PIM_LVL_W-1:0] floor_data,
    input wire logic slave_write,
    input wire logic slave_data,
    input wire logic core_ack,
    input wire logic core_eoi,
    output logic core_intr,
    output logic [pim_pkg::PIM_SRC_W-1:0] core_src,
    output logic [pim_pkg::PIM_NSRC-1:0] in_service,
    output logic [pim_pkg::PIM_NSRC-1:0] pending,
    output logic slave_mode
);
    import pim_pkg::*;

    // cfg_data layout: bits 2:0 level, 3 mask, 4 trigger, 5 cascade, 6 nest.
    localparam int F_LVL = 0;
    localparam int F_MSK = 3;
    localparam int F_TRG = 4;
    localparam int F_CAS = 5;
    localparam int F_NST = 6;

    // ************************************************************
    // Settings registers.
    // ************************************************************
    logic [PIM_LVL_W-1:0] urgency_level_field [PIM_NSRC];
    logic [PIM_NSRC-1:0] source_mask_bit;
    logic [PIM_NSRC-1:0] trigger_select;
    logic [PIM_NSRC-1:0] cascade_enable;
    logic [PIM_NSRC-1:0] special_nest_select;
    logic [PIM_LVL_W-1:0] urgency_floor_mask;

    // Per-source settings written a whole sixteen-bit word at a time.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < PIM_NSRC; i++)
            begin
                urgency_level_field[i] <= PIM_LVL_LOWEST;
            end
            source_mask_bit <= {PIM_NSRC{PIM_MASK_RST}};
            trigger_select <= {PIM_NSRC{PIM_TRIG_RST}};
            cascade_enable <= {PIM_NSRC{PIM_CASC_RST}};
            special_nest_select <= {PIM_NSRC{PIM_NEST_RST}};
        end
        else if (cfg_write)
        begin
            urgency_level_field[cfg_src] <= cfg_data[F_LVL +: PIM_LVL_W];
            source_mask_bit[cfg_src] <= cfg_data[F_MSK];
            trigger_select[cfg_src] <= cfg_data[F_TRG];
            cascade_enable[cfg_src] <= cfg_data[F_CAS];
            special_nest_select[cfg_src] <= cfg_data[F_NST];
        end
    end

    // Threshold register; all ones lets every level through.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            urgency_floor_mask <= PIM_FLOOR_RST;
        else if (floor_write)
            urgency_floor_mask <= floor_data;
    end

    // Mode bit from the relocation register; master after reset.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            slave_mode <= PIM_SLAVE_RST;
        else if (slave_write)
            slave_mode <= slave_data;
    end

    // ************************************************************
    // Input capture.
    // ************************************************************
    logic [PIM_NEXT-1:0] ext_s1, ext_s2, ext_s3;
    logic [PIM_NSRC-1:0] raw_now, raw_prev;

    // Pins pass three flops; a change counts when the last two agree.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ext_s1 <= '0;
            ext_s2 <= '0;
            ext_s3 <= '0;
        end
        else
        begin
            ext_s1 <= ext_req_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // Internal sources are gated by their own unit enable.
    always_comb
    begin
        raw_now[PIM_NINT-1:0] = int_req & unit_enable;
        for (int i = 0; i < PIM_NEXT; i++)
        begin
            raw_now[PIM_NINT+i] = (ext_s2[i] == ext_s3[i]) ? ext_s3[i] : raw_prev[PIM_NINT+i];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            raw_prev <= '0;
        else
            raw_prev <= raw_now;
    end

    // ************************************************************
    // Pending and in-service tracking.
    // ************************************************************
    pim_state_t state;
    logic found;
    logic [PIM_SRC_W-1:0] winner;
    logic [PIM_LVL_W-1:0] win_level;
    logic [PIM_NSRC-1:0] edge_hit, eligible, take_bit, done_bit;
    logic [PIM_NSRC*PIM_LVL_W-1:0] lvl_flat;
    logic [PIM_SRC_W-1:0] serving_src;

    // A new edge beats a clear from acknowledge in the same cycle.
    assign edge_hit = raw_now & ~raw_prev;
    assign take_bit = (state == PIM_OFFER && core_ack) ? (PIM_NSRC'(1) << core_src) : '0;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            pending <= '0;
        else
        begin
            for (int i = 0; i < PIM_NSRC; i++)
            begin
                if (trigger_select[i])
                    pending[i] <= raw_now[i];
                else if (edge_hit[i])
                    pending[i] <= 1'b1;
                else if (take_bit[i])
                    pending[i] <= 1'b0;
            end
        end
    end

    // The lowest in-service level blocks lower urgency, and equal urgency unless the source's special nest bit is set.
    function automatic logic blocked(input logic [PIM_LVL_W-1:0] lvl, input logic nest);
        blocked = 1'b0;
        for (int j = 0; j < PIM_NSRC; j++)
        begin
            if (in_service[j] && (lvl > urgency_level_field[j] ||
                (lvl == urgency_level_field[j] && !nest)))
                blocked = 1'b1;
        end
    endfunction

    always_comb
    begin
        for (int i = 0; i < PIM_NSRC; i++)
        begin
            lvl_flat[i*PIM_LVL_W +: PIM_LVL_W] = urgency_level_field[i];
            eligible[i] = pending[i] && !source_mask_bit[i]
                && urgency_level_field[i] <= urgency_floor_mask
                && !blocked(urgency_level_field[i], special_nest_select[i]);
        end
    end

    pim_pick #(.NSRC(PIM_NSRC)) u_pick
    (
        .eligible(eligible),
        .levels(lvl_flat),
        .found(found),
        .winner(winner),
        .win_level(win_level)
    );

    // End of interrupt clears the highest-priority in-service source.
    assign done_bit = core_eoi ? (PIM_NSRC'(1) << serving_src) : '0;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            in_service <= '0;
        else
            in_service <= (in_service & ~done_bit) | take_bit;
    end

    // Track the most urgent in-service source for end of interrupt.
    always_comb
    begin
        serving_src = '0;
        for (int i = PIM_NSRC-1; i >= 0; i--)
        begin
            if (in_service[i] && (!in_service[serving_src] ||
                urgency_level_field[i] <= urgency_level_field[serving_src]))
                serving_src = PIM_SRC_W'(i);
        end
    end

    // ************************************************************
    // Delivery to the core, one request at a time.
    // ************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= PIM_IDLE;
            core_intr <= 1'b0;
            core_src <= '0;
        end
        else
        begin
            unique case (state)
                PIM_IDLE:
                begin
                    if (found)
                    begin
                        state <= PIM_OFFER;
                        core_intr <= 1'b1;
                        core_src <= winner;
                    end
                end
                PIM_OFFER:
                begin
                    if (core_ack)
                    begin
                        state <= PIM_SERVE;
                        core_intr <= 1'b0;
                    end
                    else if (!eligible[core_src])
                    begin
                        state <= PIM_IDLE; // Request withdrawn before acknowledge.
                        core_intr <= 1'b0;
                    end
                end
                PIM_SERVE:
                begin
                    state <= PIM_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Checks.
    // ************************************************************
    // Reset clears request, service and offer state.
    a_reset_state: assert property (@(posedge sys_clk)
        rst |=> pending == '0 && in_service == '0 && !core_intr)
        else $error("State not cleared by reset.");
    a_reset_mask: assert property (@(posedge sys_clk)
        rst |=> source_mask_bit == '1 && urgency_floor_mask == '1)
        else $error("Masks not set by reset.");
    a_reset_master: assert property (@(posedge sys_clk)
        rst |=> !slave_mode && trigger_select == '0)
        else $error("Mode not master or trigger not edge after reset.");
    // The flat copy shows every level field at once, so one check covers all sources.
    a_reset_levels: assert property (@(posedge sys_clk)
        rst |=> lvl_flat == '1 && special_nest_select == '0 && cascade_enable == '0)
        else $error("Levels, nest or cascade not at reset values.");

    // An offer is judged on the values that the picker saw one edge earlier.
    // A level input may drop at the very edge of the offer, so the present pending bit proves nothing.
    a_offer_unmasked: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(core_intr) |-> $past(!source_mask_bit[winner] && pending[winner]) && core_src == $past(winner))
        else $error("Offered a masked or idle source.");
    a_offer_floor: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(core_intr) |-> $past(win_level <= urgency_floor_mask))
        else $error("Offered a level above the floor.");
    // A withdrawn request must leave the offer, or the core could take a dead source.
    a_offer_withdraw: assert property (@(posedge sys_clk) disable iff (rst)
        state == PIM_OFFER && !core_ack && !eligible[core_src] |=> !core_intr)
        else $error("Withdrawn request still offered.");
    a_offer_stable: assert property (@(posedge sys_clk) disable iff (rst)
        core_intr && !core_ack |=> $stable(core_src))
        else $error("Offered source changed while on offer.");

    // Acknowledge moves the offer into service; end of interrupt releases the most urgent one.
    a_ack_service: assert property (@(posedge sys_clk) disable iff (rst)
        core_intr && core_ack |=> in_service[$past(core_src)] && !core_intr)
        else $error("Acknowledge did not set in-service.");
    a_eoi_clear: assert property (@(posedge sys_clk) disable iff (rst)
        core_eoi && !core_ack |=> !in_service[$past(serving_src)])
        else $error("End of interrupt left the source in service.");

    // Request capture on internal lines and on synchronised pins.
    a_edge_latch: assert property (@(posedge sys_clk) disable iff (rst)
        !trigger_select[0] && int_req[0] && unit_enable[0] && !raw_prev[0] |=> pending[0])
        else $error("Edge not latched.");
    a_pin_edge: assert property (@(posedge sys_clk) disable iff (rst)
        !trigger_select[PIM_NINT] && ext_s2[0] && ext_s3[0] && !raw_prev[PIM_NINT] |=> pending[PIM_NINT])
        else $error("Pin edge not latched after synchronisation.");
    a_level_follow: assert property (@(posedge sys_clk) disable iff (rst)
        trigger_select[PIM_NINT-1] |=> pending[PIM_NINT-1] == $past(raw_now[PIM_NINT-1]))
        else $error("Level request did not follow its input.");
endmodule

// ### dv/pim_core_model.sv
// Behavioural processor core that takes offered interrupts and later ends them.
`timescale 1ns/1ps
module pim_core_model
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic core_intr,
    input wire logic enable,
    input wire logic slow,
    output logic core_ack,
    output logic core_eoi
);
    int wait_cnt = 0;
    logic busy = 1'b0;
    initial core_ack = 1'b0;
    initial core_eoi = 1'b0;
    // Only one offer is taken at a time; the end of service is delayed when slow is set.
    always @(negedge sys_clk)
    begin
        core_ack <= 1'b0;
        core_eoi <= 1'b0;
        if (rst)
        begin
            busy <= 1'b0;
        end
        else if (busy)
        begin
            if (wait_cnt == 0)
            begin
                core_eoi <= 1'b1;
                busy <= 1'b0;
            end
            else
            begin
                wait_cnt <= wait_cnt - 1;
            end
        end
        else if (core_intr && enable)
        begin
            core_ack <= 1'b1;
            busy <= 1'b1;
            wait_cnt <= slow ? 6 : 0;
        end
    end
endmodule

// ### dv/pim_merger_tb_top.sv
// Self-checking bench for the priority interrupt merger.
`timescale 1ns/1ps
module pim_merger_tb_top;
    import pim_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [PIM_NINT-1:0] int_req = 4'h0;
    logic [PIM_NINT-1:0] unit_enable = 4'hf;
    logic [PIM_NEXT-1:0] ext_req_pin = 4'h0;
    logic cfg_write = 1'b0;
    logic [PIM_SRC_W-1:0] cfg_src = 3'h0;
    logic [PIM_REG_W-1:0] cfg_data = 16'h0;
    logic floor_write = 1'b0;
    logic [PIM_LVL_W-1:0] floor_data = 3'h7;
    logic slave_write = 1'b0;
    logic slave_data = 1'b0;
    logic core_en = 1'b1;
    logic slow = 1'b0;
    logic core_ack, core_eoi, core_intr, slave_mode;
    logic [PIM_SRC_W-1:0] core_src;
    logic [PIM_NSRC-1:0] in_service, pending;
    int failures = 0;
    int comparisons = 0;
    int expq[$];
    always #2.5 sys_clk = ~sys_clk;
    pim_merger pim_merger_i (.sys_clk(sys_clk), .rst(rst), .int_req(int_req), .unit_enable(unit_enable),
        .ext_req_pin(ext_req_pin), .cfg_write(cfg_write), .cfg_src(cfg_src), .cfg_data(cfg_data),
        .floor_write(floor_write), .floor_data(floor_data), .slave_write(slave_write), .slave_data(slave_data),
        .core_ack(core_ack), .core_eoi(core_eoi), .core_intr(core_intr), .core_src(core_src),
        .in_service(in_service), .pending(pending), .slave_mode(slave_mode));
    pim_core_model pim_core_model_i (.sys_clk(sys_clk), .rst(rst), .core_intr(core_intr), .enable(core_en),
        .slow(slow), .core_ack(core_ack), .core_eoi(core_eoi));
    // ************************************************************
    // Shared checking and driving tasks.
    // ************************************************************
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cfg(input int s, input int lvl, input int msk, input int trig, input int nest);
        @(negedge sys_clk);
        cfg_write = 1'b1;
        cfg_src = 3'(s);
        cfg_data = {9'h0, 1'(nest), 1'h0, 1'(trig), 1'(msk), 3'(lvl)};
        @(negedge sys_clk);
        cfg_write = 1'b0;
    endtask
    // Reset wipes any request and service state left by the previous test.
    task automatic do_reset(input int cycles);
        @(negedge sys_clk);
        rst = 1'b1;
        repeat (cycles) @(negedge sys_clk);
        rst = 1'b0;
        check("core_intr after reset", 32'h0, {31'h0, core_intr});
        check("pending after reset", 32'h0, {24'h0, pending});
        check("in_service after reset", 32'h0, {24'h0, in_service});
        check("slave_mode after reset", 32'h0, {31'h0, slave_mode});
    endtask
    // Every taken offer must be the next source that the reference ordering predicts.
    always @(posedge sys_clk)
    begin
        if (!rst && core_intr === 1'b1 && core_ack === 1'b1)
            check("served source", expq.size() > 0 ? expq.pop_front() : 32'h63, {29'h0, core_src});
    end
    // One group of four sources fires together; the model orders them by level, then index.
    task automatic run_round(input int grp);
        int lvl[4];
        int msk[4];
        int ena[4];
        int flr;
        flr = 3 + $urandom % 5;
        slow = 1'($urandom % 2);
        for (int s = 0; s < 4; s++)
        begin
            lvl[s] = $urandom % 8;
            msk[s] = ($urandom % 4) == 0;
            ena[s] = (grp == 1) || (($urandom % 4) != 0);
            cfg(4 * grp + s, lvl[s], msk[s], 0, 0);
            unit_enable[s] = 1'(ena[s]);
        end
        @(negedge sys_clk);
        floor_write = 1'b1;
        floor_data = 3'(flr);
        @(negedge sys_clk);
        floor_write = 1'b0;
        for (int l = 0; l <= flr; l++)
            for (int s = 0; s < 4; s++)
                if (lvl[s] == l && msk[s] == 0 && ena[s] != 0)
                    expq.push_back(4 * grp + s);
        if (grp == 0)
            int_req = 4'hf;
        else
            ext_req_pin = 4'hf;
        repeat (150) @(negedge sys_clk);
        check("offers left unserved", 32'h0, expq.size());
        check("in_service after round", 32'h0, {24'h0, in_service});
        int_req = 4'h0;
        ext_req_pin = 4'h0;
        expq.delete();
        do_reset(2);
        $display("Round for group %0d done", grp);
    endtask
    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial
    begin
        void'($urandom(62));
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        check("pending after first reset", 32'h0, {24'h0, pending});
        check("in_service after first reset", 32'h0, {24'h0, in_service});
        check("slave_mode after first reset", 32'h0, {31'h0, slave_mode});
        int_req = 4'h1;
        repeat (10) @(negedge sys_clk);
        check("masked source offered", 32'h0, {31'h0, core_intr});
        int_req = 4'h0;
        $display("Reset defaults test done");
        slave_write = 1'b1;
        slave_data = 1'b1;
        @(negedge sys_clk);
        slave_write = 1'b0;
        check("slave_mode set", 32'h1, {31'h0, slave_mode});
        do_reset(2);
        $display("Slave mode test done");
        core_en = 1'b0;
        cfg(3, 2, 0, 1, 0);
        int_req = 4'h8;
        repeat (3) @(negedge sys_clk);
        check("level request pending", 32'h1, {31'h0, pending[3]});
        int_req = 4'h0;
        repeat (3) @(negedge sys_clk);
        check("level request dropped", 32'h0, {31'h0, pending[3]});
        core_en = 1'b1;
        do_reset(2);
        $display("Level sense test done");
        // An equal-level source is offered during service only when its special nest bit is set.
        slow = 1'b1;
        for (int n = 1; n >= 0; n--)
        begin
            cfg(0, 2, 0, 0, 0);
            cfg(1, 2, 0, 0, n);
            expq.push_back(0);
            expq.push_back(1);
            int_req = 4'h1;
            repeat (4) @(negedge sys_clk);
            int_req = 4'h3;
            repeat (3) @(negedge sys_clk);
            check("equal level offered in service", 32'(n), {31'h0, core_intr});
            repeat (30) @(negedge sys_clk);
            check("nest offers left unserved", 32'h0, expq.size());
            int_req = 4'h0;
            do_reset(2);
        end
        $display("Nesting test done");
        for (int r = 0; r < 8; r++)
            run_round(r % 2);
        finish_test();
    end
    // A hang is cut short well after all tests should have ended.
    initial
    begin
        #100000;
        failures++;
        $display("Watchdog expired");
        finish_test();
    end
endmodule
